// [logic/status_ind.sv]
// Status-display indicator and code logic of a servo amplifier panel, with APB parameter registers.
`timescale 1ns/1ps

module status_ind
    import status_ind_pkg::*;
(
    input wire logic core_clk_in,
    input wire logic sys_rst_in,
    input wire logic clk_en_in,
    input wire core_bits_t core_bits_in,
    input wire core_vals_t core_vals_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [ADDR_W-1:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    output ind_t ind_out,
    output code_t code_out,
    output disp_mode_t disp_mode_out,
    output logic [DIGITS*NIB_W-1:0] func_sel_out
);

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    // Pin-level bits come from another domain: three stages, a change
    // counts once stages two and three agree.
    core_bits_t sync1_ff;
    core_bits_t sync2_ff;
    core_bits_t sync3_ff;
    core_bits_t bits_ff;
    core_bits_t nxt_bits;

    genvar gi;
    generate
        for (gi = 0; gi < $bits(core_bits_t); gi++) begin : g_agree
            assign nxt_bits[gi] = (sync2_ff[gi] == sync3_ff[gi]) ? sync3_ff[gi] : bits_ff[gi];
        end
    endgenerate

    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            sync1_ff <= '0;
            sync2_ff <= '0;
            sync3_ff <= '0;
            bits_ff <= '0;
        end else if (clk_en_in) begin
            sync1_ff <= core_bits_in;
            sync2_ff <= sync1_ff;
            sync3_ff <= sync2_ff;
            bits_ff <= nxt_bits;
        end
    end

    // ------------------------------------------------------------
    // Parameter registers
    // ------------------------------------------------------------
    ctrl_mode_t mode_ff;
    logic disp_en_ff;
    logic [PARAM_W-1:0] speed_match_window_ff;
    logic [PARAM_W-1:0] rotation_threshold_ff;
    logic [PARAM_W-1:0] position_done_window_ff;
    logic [PARAM_W-1:0] trq_thresh_ff;
    logic [DIGITS*NIB_W-1:0] func_sel_ff;
    logic reject_ff;

    function automatic logic in_range(input logic [PARAM_W-1:0] v,
                                      input logic [PARAM_W-1:0] lo,
                                      input logic [PARAM_W-1:0] hi);
        in_range = (v >= lo) && (v <= hi);
    endfunction

    // An access is taken on the edge where pready rises; pready then drops, so a held
    // access phase writes the register again two cycles later.
    wire wr_acc = psel_in && penable_in && pwrite_in && !pready_out;
    wire rd_acc = psel_in && penable_in && !pwrite_in && !pready_out;
    wire [PARAM_W-1:0] wval = pwdata_in[PARAM_W-1:0];
    wire hit_ctrl = (paddr_in == REG_CTRL);
    wire hit_smw = (paddr_in == REG_SPEED_MATCH);
    wire hit_rot = (paddr_in == REG_ROTATION);
    wire hit_pdw = (paddr_in == REG_POS_DONE);
    wire hit_trq = (paddr_in == REG_TRQ_REF);
    wire hit_fsel = (paddr_in == REG_FUNC_SEL);
    wire hit_stat = (paddr_in == REG_STATUS);
    wire hit_code = (paddr_in == REG_CODE);
    wire mapped = hit_ctrl || hit_smw || hit_rot || hit_pdw || hit_trq || hit_fsel || hit_stat || hit_code;

    // Out-of-range value writes are dropped and flagged; the old value stays.
    wire ok_smw = in_range(wval, SPEED_MATCH_MIN, SPEED_MATCH_MAX);
    wire ok_rot = in_range(wval, ROTATION_MIN, ROTATION_MAX);
    wire ok_pdw = in_range(wval, POS_DONE_MIN, POS_DONE_MAX);
    wire ok_trq = in_range(wval, TRQ_REF_MIN, TRQ_REF_MAX);
    wire [1:0] wmode = pwdata_in[CTRL_MODE_LSB +: 2];
    wire ok_mode = (wmode <= 2'(MODE_POSITION));
    wire bad_val = (hit_smw && !ok_smw) || (hit_rot && !ok_rot) || (hit_pdw && !ok_pdw) ||
                   (hit_trq && !ok_trq) || (hit_ctrl && !ok_mode);

    // Each digit takes the written nibble only when its own bit is enabled
    // by the write mask in bits 24 up; the other digits are untouched.
    logic [DIGITS*NIB_W-1:0] nxt_func_sel;
    generate
        for (gi = 0; gi < DIGITS; gi++) begin : g_digit
            wire dig_we = wr_acc && hit_fsel && pwdata_in[FSEL_WE_LSB+gi]
                          && (pwdata_in[gi*NIB_W +: NIB_W] <= FUNC_DIGIT_MAX);
            assign nxt_func_sel[gi*NIB_W +: NIB_W] = dig_we ? pwdata_in[gi*NIB_W +: NIB_W]
                                                            : func_sel_ff[gi*NIB_W +: NIB_W];
        end
    endgenerate

    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            mode_ff <= MODE_SPEED;
            disp_en_ff <= 1'b1;
            speed_match_window_ff <= SPEED_MATCH_DEF;
            rotation_threshold_ff <= ROTATION_DEF;
            position_done_window_ff <= POS_DONE_DEF;
            trq_thresh_ff <= TRQ_REF_DEF;
            func_sel_ff <= FUNC_SEL_DEF;
            reject_ff <= 1'b0;
        end else if (clk_en_in) begin
            func_sel_ff <= nxt_func_sel;
            if (wr_acc) begin
                reject_ff <= bad_val || !mapped;
                if (hit_ctrl && ok_mode) begin
                    mode_ff <= ctrl_mode_t'(wmode);
                    disp_en_ff <= pwdata_in[CTRL_DISP_EN];
                end
                if (hit_smw && ok_smw) speed_match_window_ff <= wval;
                if (hit_rot && ok_rot) rotation_threshold_ff <= wval;
                if (hit_pdw && ok_pdw) position_done_window_ff <= wval;
                if (hit_trq && ok_trq) trq_thresh_ff <= wval;
            end
        end
    end

    // ------------------------------------------------------------
    // Indicator evaluation
    // ------------------------------------------------------------
    wire signed [SPD_W:0] spd_diff = core_vals_in.motor_speed - core_vals_in.ref_speed;
    wire [SPD_W:0] spd_err = spd_diff[SPD_W] ? (SPD_W+1)'(-spd_diff) : spd_diff;
    wire [SPD_W-1:0] mot_abs = core_vals_in.motor_speed[SPD_W-1] ?
                               SPD_W'(-core_vals_in.motor_speed) : core_vals_in.motor_speed;
    wire [SPD_W-1:0] ref_abs = core_vals_in.ref_speed[SPD_W-1] ?
                               SPD_W'(-core_vals_in.ref_speed) : core_vals_in.ref_speed;
    wire [TRQ_W-1:0] trq_abs = core_vals_in.ref_torque[TRQ_W-1] ?
                               TRQ_W'(-core_vals_in.ref_torque) : core_vals_in.ref_torque;
    wire [POS_W-1:0] pos_abs = core_vals_in.pos_error[POS_W-1] ?
                               POS_W'(-core_vals_in.pos_error) : core_vals_in.pos_error;

    wire is_pos = (mode_ff == MODE_POSITION);
    wire is_trq = (mode_ff == MODE_TORQUE);
    wire spd_match = is_trq || (spd_err <= (SPD_W+1)'(speed_match_window_ff));
    wire pos_done = (pos_abs < POS_W'(position_done_window_ff));
    wire rotating = (mot_abs > rotation_threshold_ff);
    wire spd_ref_on = (ref_abs > rotation_threshold_ff);
    wire trq_ref_on = (PARAM_W'(trq_abs) > trq_thresh_ff);

    ind_t nxt_ind;
    assign nxt_ind.ctrl_pwr = bits_ff.ctrl_pwr;
    assign nxt_ind.baseblock = !bits_ff.servo_on;
    assign nxt_ind.match_done = is_pos ? pos_done : spd_match;
    assign nxt_ind.rotating = rotating;
    assign nxt_ind.spd_or_pulse = is_pos ? bits_ff.pulse_active : spd_ref_on;
    assign nxt_ind.trq_or_clear = is_pos ? bits_ff.clear_active : trq_ref_on;
    assign nxt_ind.pwr_ready = bits_ff.main_pwr_ok;
    assign nxt_ind.pos_set = is_pos;

    // ------------------------------------------------------------
    // Status code selection
    // ------------------------------------------------------------
    // Limit inputs are active-high "on": off means travel is prohibited.
    code_kind_t nxt_kind;
    assign nxt_kind = bits_ff.alarm ? CODE_ALARM :
                      !bits_ff.fwd_limit ? CODE_FWD_PROHIBIT :
                      !bits_ff.rev_limit ? CODE_REV_PROHIBIT :
                      bits_ff.servo_on ? CODE_RUN : CODE_BASEBLOCK;

    code_t nxt_code;
    assign nxt_code.kind = nxt_kind;
    assign nxt_code.alarm_num = bits_ff.alarm ? core_vals_in.alarm_num : '0;

    // ------------------------------------------------------------
    // Output registers
    // ------------------------------------------------------------
    // Display mode stays in status mode out of reset; software may leave it
    // only through the control register display-enable bit.
    disp_mode_t nxt_disp;
    assign nxt_disp = disp_en_ff ? DISP_STATUS : DISP_PARAM;

    wire [31:0] rd_mux = hit_ctrl ? {29'h0, disp_en_ff, 2'(mode_ff)} :
                         hit_smw ? {16'h0, speed_match_window_ff} :
                         hit_rot ? {16'h0, rotation_threshold_ff} :
                         hit_pdw ? {16'h0, position_done_window_ff} :
                         hit_trq ? {16'h0, trq_thresh_ff} :
                         hit_fsel ? {12'h0, func_sel_ff} :
                         hit_stat ? {21'h0, 2'(disp_mode_out), reject_ff, ind_out} :
                         hit_code ? {21'h0, 3'(code_out.kind), code_out.alarm_num} : 32'h0;

    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            ind_out <= '0;
            code_out <= '{kind: CODE_BASEBLOCK, alarm_num: '0};
            disp_mode_out <= DISP_STATUS;
            func_sel_out <= FUNC_SEL_DEF;
            prdata_out <= 32'h0;
            pready_out <= 1'b0;
            pslverr_out <= 1'b0;
        end else if (clk_en_in) begin
            ind_out <= nxt_ind;
            code_out <= nxt_code;
            disp_mode_out <= nxt_disp;
            func_sel_out <= func_sel_ff;
            // One wait state: pready rises in the second access cycle.
            pready_out <= psel_in && penable_in && !pready_out;
            pslverr_out <= psel_in && penable_in && !pready_out && (!mapped || (pwrite_in && bad_val));
            if (rd_acc && !pready_out) prdata_out <= rd_mux;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    AST_CTRL_PWR: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
        clk_en_in |=> ind_out.ctrl_pwr == $past(bits_ff.ctrl_pwr))
        else $error("Control power indicator does not follow control power.");
    AST_BASEBLOCK: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
        clk_en_in && bits_ff.servo_on |=> !ind_out.baseblock)
        else $error("Baseblock indicator lit while servo on.");
    AST_TRQ_MATCH: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
        clk_en_in && is_trq |=> ind_out.match_done)
        else $error("Speed match indicator dark in torque mode.");
    AST_SPD_MATCH: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
        clk_en_in && mode_ff == MODE_SPEED && spd_err > (SPD_W+1)'(speed_match_window_ff) |=> !ind_out.match_done)
        else $error("Speed match lit outside window.");
    AST_ROTATE: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
        clk_en_in && mot_abs > rotation_threshold_ff |=> ind_out.rotating)
        else $error("Rotating flag dark above threshold.");
    AST_POS_DONE: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
        clk_en_in && is_pos && pos_abs >= POS_W'(position_done_window_ff) |=> !ind_out.match_done)
        else $error("Positioning done lit outside window.");
    AST_ALARM_FIRST: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
        clk_en_in && bits_ff.alarm |=> code_out.kind == CODE_ALARM && code_out.alarm_num == $past(core_vals_in.alarm_num))
        else $error("Alarm number not shown while alarm active.");
    AST_FWD_OT: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
        clk_en_in && !bits_ff.alarm && !bits_ff.fwd_limit |=> code_out.kind == CODE_FWD_PROHIBIT)
        else $error("Forward prohibit code missing.");
    AST_RUN_CODE: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
        clk_en_in && !bits_ff.alarm && bits_ff.fwd_limit && bits_ff.rev_limit
        |=> code_out.kind == ($past(bits_ff.servo_on) ? CODE_RUN : CODE_BASEBLOCK))
        else $error("Run or baseblock code wrong.");
    AST_RANGE: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
        clk_en_in && wr_acc && hit_rot && !ok_rot |=> $stable(rotation_threshold_ff))
        else $error("Out of range value accepted.");

endmodule

// [logic/status_ind_pkg.sv]
// Package for the servo status indicator logic: constants, enums and carrier structs.
package status_ind_pkg;

    // ------------------------------------------------------------
    // Widths and reset values
    // ------------------------------------------------------------
    localparam int SPD_W = 16;
    localparam int POS_W = 24;
    localparam int TRQ_W = 12;
    localparam int ALM_W = 8;
    localparam int PARAM_W = 16;
    localparam int DIGITS = 5;
    localparam int NIB_W = 4;

    // Speeds in rpm, torque in tenths of a percent of rated torque.
    localparam logic [PARAM_W-1:0] SPEED_MATCH_DEF = 16'h000A;
    localparam logic [PARAM_W-1:0] ROTATION_DEF = 16'h0014;
    localparam logic [PARAM_W-1:0] POS_DONE_DEF = 16'h0007;
    localparam logic [PARAM_W-1:0] TRQ_REF_DEF = 16'h0064;

    // Permitted range of each value parameter.
    localparam logic [PARAM_W-1:0] SPEED_MATCH_MIN = 16'h0000;
    localparam logic [PARAM_W-1:0] SPEED_MATCH_MAX = 16'h0064;
    localparam logic [PARAM_W-1:0] ROTATION_MIN = 16'h0001;
    localparam logic [PARAM_W-1:0] ROTATION_MAX = 16'h2710;
    localparam logic [PARAM_W-1:0] POS_DONE_MIN = 16'h0000;
    localparam logic [PARAM_W-1:0] POS_DONE_MAX = 16'h00FA;
    localparam logic [PARAM_W-1:0] TRQ_REF_MIN = 16'h0000;
    localparam logic [PARAM_W-1:0] TRQ_REF_MAX = 16'h03E8;

    // Per-digit maximum of the function-selection word.
    localparam logic [NIB_W-1:0] FUNC_DIGIT_MAX = 4'hF;
    localparam logic [DIGITS*NIB_W-1:0] FUNC_SEL_DEF = 20'h00000;

    // ------------------------------------------------------------
    // APB register map (byte addresses)
    // ------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] REG_SPEED_MATCH = 8'h04;
    localparam logic [ADDR_W-1:0] REG_ROTATION = 8'h08;
    localparam logic [ADDR_W-1:0] REG_POS_DONE = 8'h0C;
    localparam logic [ADDR_W-1:0] REG_TRQ_REF = 8'h10;
    localparam logic [ADDR_W-1:0] REG_FUNC_SEL = 8'h14;
    localparam logic [ADDR_W-1:0] REG_STATUS = 8'h18;
    localparam logic [ADDR_W-1:0] REG_CODE = 8'h1C;

    // CTRL register bit positions.
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_DISP_EN = 2;
    // STATUS register: indicators in bits 7:0, reject flag, display mode.
    localparam int STAT_REJECT = 8;
    localparam int STAT_MODE_LSB = 9;
    // FUNC_SEL register: per-digit write enables start at this bit.
    localparam int FSEL_WE_LSB = 24;

    // ------------------------------------------------------------
    // Enumerations
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        MODE_SPEED,
        MODE_TORQUE,
        MODE_POSITION
    } ctrl_mode_t;

    typedef enum logic [2:0] {
        CODE_BASEBLOCK,
        CODE_RUN,
        CODE_FWD_PROHIBIT,
        CODE_REV_PROHIBIT,
        CODE_ALARM
    } code_kind_t;

    typedef enum logic [1:0] {
        DISP_STATUS,
        DISP_AUX,
        DISP_PARAM,
        DISP_MONITOR
    } disp_mode_t;

    // ------------------------------------------------------------
    // Carrier structs
    // ------------------------------------------------------------
    typedef struct packed {
        logic ctrl_pwr;
        logic main_pwr_ok;
        logic servo_on;
        logic fwd_limit;
        logic rev_limit;
        logic pulse_active;
        logic clear_active;
        logic alarm;
    } core_bits_t;

    typedef struct packed {
        logic signed [SPD_W-1:0] motor_speed;
        logic signed [SPD_W-1:0] ref_speed;
        logic signed [TRQ_W-1:0] ref_torque;
        logic signed [POS_W-1:0] pos_error;
        logic [ALM_W-1:0] alarm_num;
    } core_vals_t;

    // Bit 7 ctrl power, 6 baseblock, 5 match/done, 4 rotating,
    // 3 speed ref/pulse, 2 torque ref/clear, 1 power ready, 0 position set.
    typedef struct packed {
        logic ctrl_pwr;
        logic baseblock;
        logic match_done;
        logic rotating;
        logic spd_or_pulse;
        logic trq_or_clear;
        logic pwr_ready;
        logic pos_set;
    } ind_t;

    typedef struct packed {
        code_kind_t kind;
        logic [ALM_W-1:0] alarm_num;
    } code_t;

endpackage

// [tb/core_model.sv]
// Behavioural model of the servo control core that feeds the status logic.
`timescale 1ns/1ps
module core_model
    import status_ind_pkg::*;
(
    input wire logic core_clk_in,
    input wire core_bits_t bits_in,
    input wire core_vals_t vals_in,
    output core_bits_t core_bits_out,
    output core_vals_t core_vals_out
);
    // Levels launch just after an edge, as the core's own registers would drive them.
    always_ff @(posedge core_clk_in) begin
        core_bits_out <= bits_in;
        core_vals_out <= vals_in;
    end
endmodule

// [tb/testbench.sv]
// Self-checking testbench of the status indicator logic over its pins and APB registers.
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin errors++; \
    $display("[ERR] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module testbench;
    import status_ind_pkg::*;
    logic core_clk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic clk_en = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    core_bits_t set_bits = 8'hF8;
    core_vals_t set_vals = '0;
    core_bits_t core_bits;
    core_vals_t core_vals;
    ind_t ind;
    code_t code;
    disp_mode_t disp_mode;
    logic [19:0] func_sel;
    logic [31:0] shadow [8];
    core_bits_t btab [10] = '{8'hF8, 8'hD8, 8'hFC, 8'hFA, 8'hB8, 8'h78, 8'hE8, 8'hF0, 8'hE0, 8'hE9};
    core_vals_t vtab [4];
    logic [7:0] pa [10] = '{8'h08, 8'h08, 8'h08, 8'h04, 8'h04, 8'h0C, 8'h0C, 8'h10, 8'h10, 8'h00};
    logic [31:0] pd [10] = '{32'h0, 32'h2711, 32'h1E, 32'h65, 32'h64, 32'hFB, 32'hFA, 32'h3E9, 32'h3E8, 32'h7};
    logic pb [10] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
    logic [31:0] fd [3] = '{32'h01000005, 32'h040AAAAA, 32'h1F012345};
    logic [19:0] fe [3] = '{20'h00005, 20'h00A05, 20'h12345};
    logic [31:0] rd;
    logic err;
    int errors = 0;
    int n_compared = 0;
    int cycles = 0;

    always #2.5 core_clk_in = ~core_clk_in;

    core_model PARTNER (.core_clk_in(core_clk_in), .bits_in(set_bits), .vals_in(set_vals),
        .core_bits_out(core_bits), .core_vals_out(core_vals));

    status_ind DUT (.core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in), .clk_en_in(clk_en),
        .core_bits_in(core_bits), .core_vals_in(core_vals), .psel_in(psel), .penable_in(penable),
        .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
        .pready_out(pready), .pslverr_out(pslverr), .ind_out(ind), .code_out(code),
        .disp_mode_out(disp_mode), .func_sel_out(func_sel));

    // ------------------------------------------------------------
    // Reference model
    // ------------------------------------------------------------
    function automatic core_vals_t mk(int ms, int rs, int rt, int pe, int alm);
        core_vals_t v;
        v.motor_speed = ms[15:0];
        v.ref_speed = rs[15:0];
        v.ref_torque = rt[11:0];
        v.pos_error = pe[23:0];
        v.alarm_num = alm[7:0];
        return v;
    endfunction

    function automatic ind_t exp_ind(core_bits_t b, core_vals_t v);
        int ms, rs, rt, pe, d, ma, ra;
        ind_t e;
        logic pos;
        ms = v.motor_speed;
        rs = v.ref_speed;
        rt = v.ref_torque;
        // Thresholds compare magnitudes, so reverse speeds and torques count too.
        rt = rt < 0 ? -rt : rt;
        ma = ms < 0 ? -ms : ms;
        ra = rs < 0 ? -rs : rs;
        pe = v.pos_error < 0 ? -v.pos_error : v.pos_error;
        d = ms > rs ? ms - rs : rs - ms;
        pos = shadow[0][1:0] == 2'h2;
        e.ctrl_pwr = b.ctrl_pwr;
        e.baseblock = !b.servo_on;
        e.rotating = ma > int'(shadow[2]);
        e.match_done = pos ? pe < int'(shadow[3]) : (shadow[0][1:0] == 2'h1 || d <= int'(shadow[1]));
        e.spd_or_pulse = pos ? b.pulse_active : ra > int'(shadow[2]);
        e.trq_or_clear = pos ? b.clear_active : rt > int'(shadow[4]);
        e.pwr_ready = b.main_pwr_ok;
        e.pos_set = pos;
        return e;
    endfunction

    function automatic code_t exp_code(core_bits_t b, core_vals_t v);
        code_t c;
        c.alarm_num = b.alarm ? v.alarm_num : 8'h00;
        if (b.alarm) c.kind = CODE_ALARM;
        else if (!b.fwd_limit) c.kind = CODE_FWD_PROHIBIT;
        else if (!b.rev_limit) c.kind = CODE_REV_PROHIBIT;
        else c.kind = b.servo_on ? CODE_RUN : CODE_BASEBLOCK;
        return c;
    endfunction

    // ------------------------------------------------------------
    // Bus and pin tasks
    // ------------------------------------------------------------
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        @(posedge core_clk_in);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk_in);
        penable <= 1'b1;
        do begin
            @(posedge core_clk_in);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic step(input core_bits_t b, input core_vals_t v);
        code_t ec;
        @(posedge core_clk_in);
        set_bits <= b;
        set_vals <= v;
        // Pin levels pass a synchroniser, so give them a settled margin.
        repeat (8) @(posedge core_clk_in);
        ec = exp_code(b, v);
        `CHK(ind, exp_ind(b, v))
        `CHK(code, ec)
        apb(1'b0, REG_CODE, 32'h0, rd, err);
        `CHK(rd[10:0], ec)
    endtask

    task automatic wcheck(input logic [7:0] a, input logic [31:0] d, input logic bad);
        apb(1'b1, a, d, rd, err);
        `CHK(err, bad)
        if (!bad) shadow[a[4:2]] = d;
        apb(1'b0, a, 32'h0, rd, err);
        `CHK(rd, shadow[a[4:2]])
        apb(1'b0, REG_STATUS, 32'h0, rd, err);
        `CHK(rd[8], bad)
    endtask

    task automatic test_done;
        $display("compared %0d, mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Runs take about 700 cycles; the ceiling leaves ample margin.
    always @(posedge core_clk_in) begin
        cycles++;
        if (cycles == 8000) begin
            errors++;
            test_done();
        end
    end

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        shadow = '{32'h4, 32'hA, 32'h14, 32'h7, 32'h64, 32'h0, 32'h0, 32'h0};
        vtab = '{mk(100, 110, 101, 6, 0), mk(100, 111, 100, 7, 8'h5C), mk(20, 20, 0, -6, 0), mk(21, -30, 5, -7, 8'h3A)};
        repeat (12) @(posedge core_clk_in);
        sys_rst_in <= 1'b0;
        for (int i = 0; i < 6; i++) begin
            apb(1'b0, 8'(i * 4), 32'h0, rd, err);
            `CHK(rd, shadow[i])
        end
        `CHK(disp_mode, DISP_STATUS)
        apb(1'b0, 8'h20, 32'h0, rd, err);
        `CHK({err, rd}, {1'b1, 32'h0})
        $display("test reset_defaults done");
        for (int m = 0; m < 3; m++) begin
            wcheck(REG_CTRL, 32'(m) | 32'h4, 1'b0);
            for (int i = 0; i < 10; i++) step(btab[i], vtab[i % 4]);
        end
        $display("test modes_and_codes done");
        wcheck(REG_CTRL, 32'h4, 1'b0);
        for (int i = 0; i < 10; i++) wcheck(pa[i], pd[i], pb[i]);
        step(8'hF8, mk(31, -60, 1001, -249, 0));
        step(8'hF8, mk(30, 130, 999, 0, 0));
        // With the enable low nothing moves; the change lands once it is back.
        @(posedge core_clk_in);
        clk_en <= 1'b0;
        set_bits <= 8'h78;
        repeat (8) @(posedge core_clk_in);
        `CHK(ind, exp_ind(8'hF8, mk(30, 130, 999, 0, 0)))
        clk_en <= 1'b1;
        step(8'h78, mk(30, 130, 999, 0, 0));
        wcheck(REG_CTRL, 32'h0, 1'b0);
        `CHK(rd[10:9], 2'(DISP_PARAM))
        `CHK(disp_mode, DISP_PARAM)
        wcheck(REG_CTRL, 32'h4, 1'b0);
        `CHK(disp_mode, DISP_STATUS)
        $display("test parameter_ranges done");
        for (int i = 0; i < 3; i++) begin
            apb(1'b1, REG_FUNC_SEL, fd[i], rd, err);
            @(posedge core_clk_in);
            `CHK(func_sel, fe[i])
            apb(1'b0, REG_FUNC_SEL, 32'h0, rd, err);
            `CHK(rd[19:0], fe[i])
        end
        $display("test function_digits done");
        test_done();
    end
endmodule
